// >>> src/smpm_top.sv
// Supply monitor, undervoltage reset cause and power-mode sequencer with an APB slave.
// Assumes analog inputs are asynchronous, CPU events are single-cycle pulses on clk,
// and por_b is released only at power-on, not by external or watchdog resets.
//
// Behaviour
// - Warning flag reads comparator live; writes ignored.
// - Warning flag set/cleared by hardware only.
// - Both warning transitions raise an interrupt.
// - Two-bit field selects the warning threshold.
// - Interrupt needs enable bit and clear mask.
// - Pending warning cleared on service routine entry.
// - Wait keeps monitor running; warning wakes it.
// - Halt freezes status; warning cannot wake.
// - Undervoltage flag set by hardware, read clears.
// - Other resets leave undervoltage flag untouched.
// - Undervoltage flag undefined with detector disabled.
// - Short dips may not set undervoltage flag.
// - External clock: no flag in halt; needs fast.
// - Reserved, warning, enable read zero after reset.
// - Reset starts in Run with full clock.
// - Slow select divides clock by thirty-two.
// - Wait from Slow gives Slow-wait mode.
// - Wait stops CPU, peripherals keep running.
// - Wait entry clears the global interrupt mask.
// - Wait lasts until interrupt or reset.
`timescale 1ns/1ps
`include "smpm_map.svh"
module smpm_top #(
  parameter int SLOW_DIV = `SMPM_SLOW_DIV,
  parameter int DIP_CYCLES = `SMPM_DIP_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic por_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire smpm_pkg::smpm_cpu_evt_t cpu_evt,
  input wire smpm_pkg::smpm_analog_t analog_in,
  output logic [1:0] warn_threshold_field,
  output logic [1:0] osc_trim_low_bits,
  output logic irq_req,
  output logic irq_mask,
  output logic cpu_clk_tick,
  output logic periph_clk_tick,
  output logic wake_pulse,
  output smpm_pkg::smpm_mode_t power_mode
);
  import smpm_pkg::*;

  initial begin
    if (SLOW_DIV != 32) $error("smpm_top: only a divide-by-32 slow mode is supported");
    if (DIP_CYCLES < 1 || DIP_CYCLES > 65535) $error("smpm_top: DIP_CYCLES out of range");
  end

  smpm_analog_t an_s;  // Synchronised analog levels
  logic slow_tick;  // Slow-mode divider tick

  // Comparator and option levels pass two flops before use
  smpm_sync #(.WIDTH($bits(smpm_analog_t))) u_sync (
    .clk(clk),
    .rst_b(por_b),  // Power-on only, so a dip is still tracked while the system reset is held
    .d(analog_in),
    .q(an_s)
  );

  // One tick every 32 oscillator cycles for slow mode
  smpm_tick_div #(.RATIO(SLOW_DIV)) u_div (
    .clk(clk),
    .rst_b(rst_b),
    .tick(slow_tick)
  );

  // Match of a byte address's word index against a register index
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a[11:2] == {2'b00, idx});
  endfunction

  // APB slave state
  logic [31:0] prdata_nxt;
  logic pready_nxt;
  logic pslverr_nxt;
  logic acc_done;     // Transfer completes at this edge
  logic wr_cs;        // Write to control/status
  logic wr_th;        // Write to threshold select
  logic wr_mc;        // Write to mode control
  logic rd_cs;        // Read of control/status
  logic mapped;       // Address maps to a register
  // Register state
  logic irq_en_r, irq_en_nxt;              // Warning interrupt enable
  logic warn_flag_r, warn_flag_nxt;        // Displayed warning flag
  logic [1:0] trim_r, trim_nxt;            // Low oscillator trim bits
  logic [1:0] th_field_r, th_field_nxt;    // Warning threshold field
  logic [2:0] th_clk_r, th_clk_nxt;        // Clock-select storage bits
  logic slow_sel_r, slow_sel_nxt;          // Slow-mode select bit
  logic pend_r, pend_nxt;                  // Pending warning interrupt
  // Power-on domain state
  logic uv_flag_r, uv_flag_nxt;            // Undervoltage reset flag
  logic [15:0] dip_cnt_r, dip_cnt_nxt;     // Length of current dip
  logic dip_halt_r, dip_halt_nxt;          // Dip began while in Halt
  logic uv_prev_r, uv_prev_nxt;            // Last synchronised uv level
  // Mode state
  smpm_mode_t mode_r, mode_nxt;
  logic mask_r, mask_nxt;
  logic irq_r, irq_nxt;
  logic cpu_tick_r, cpu_tick_nxt;
  logic per_tick_r, per_tick_nxt;
  logic wake_r, wake_nxt;
  logic in_halt;
  logic warn_event;

  assign in_halt = (mode_r == SMPM_HALT);

  // Bus decode; a transfer completes on the edge where pready is high
  always_comb begin
    acc_done = psel && penable && pready;
    mapped = hit(paddr, `SMPM_IDX_CTRL_STATUS) || hit(paddr, `SMPM_IDX_THRESH_SEL) || hit(paddr, `SMPM_IDX_MODE_CTRL);
    wr_cs = acc_done && pwrite && hit(paddr, `SMPM_IDX_CTRL_STATUS);
    wr_th = acc_done && pwrite && hit(paddr, `SMPM_IDX_THRESH_SEL);
    wr_mc = acc_done && pwrite && hit(paddr, `SMPM_IDX_MODE_CTRL);
    rd_cs = acc_done && !pwrite && hit(paddr, `SMPM_IDX_CTRL_STATUS);
  end

  // One wait state: pready rises for the second access cycle, read data with it
  always_comb begin
    pready_nxt = psel && penable && !pready;
    pslverr_nxt = psel && penable && !pready && !mapped;
    prdata_nxt = 32'h0000_0000;
    if (psel && penable && !pready && !pwrite) begin
      if (hit(paddr, `SMPM_IDX_CTRL_STATUS)) begin
        // Reserved bits 7 and 4:3 always read zero
        prdata_nxt[`SMPM_CS_TRIM_MSB:`SMPM_CS_TRIM_LSB] = trim_r;
        prdata_nxt[`SMPM_CS_UV_BIT] = uv_flag_r;
        prdata_nxt[`SMPM_CS_WARN_BIT] = warn_flag_r;
        prdata_nxt[`SMPM_CS_IRQ_EN_BIT] = irq_en_r;
      end else if (hit(paddr, `SMPM_IDX_THRESH_SEL)) begin
        prdata_nxt[7:`SMPM_TH_CLKSEL_LSB] = th_clk_r;
        prdata_nxt[`SMPM_TH_FIELD_MSB:0] = th_field_r;
      end else if (hit(paddr, `SMPM_IDX_MODE_CTRL)) begin
        prdata_nxt[`SMPM_MC_SLOW_BIT] = slow_sel_r;
        prdata_nxt[`SMPM_MC_MODE_MSB:`SMPM_MC_MODE_LSB] = mode_r;
        prdata_nxt[`SMPM_MC_MASK_BIT] = mask_r;
      end
    end
  end

  // Bus answer flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      prdata <= prdata_nxt;
    end
  end

  // Software-visible control registers and the warning flag
  always_comb begin
    irq_en_nxt = irq_en_r;
    trim_nxt = trim_r;
    th_field_nxt = th_field_r;
    th_clk_nxt = th_clk_r;
    slow_sel_nxt = slow_sel_r;
    // Flag follows the synchronised comparator, hardware only
    // and is held frozen while halted
    warn_flag_nxt = in_halt ? warn_flag_r : an_s.warn_cmp;
    if (wr_cs && !in_halt) begin
      // The warning flag bit of the write data is dropped
      irq_en_nxt = pwdata[`SMPM_CS_IRQ_EN_BIT];
      trim_nxt = pwdata[`SMPM_CS_TRIM_MSB:`SMPM_CS_TRIM_LSB];
    end
    if (wr_th) begin
      th_field_nxt = pwdata[`SMPM_TH_FIELD_MSB:0];
      th_clk_nxt = pwdata[7:`SMPM_TH_CLKSEL_LSB];
    end
    if (wr_mc) begin
      slow_sel_nxt = pwdata[`SMPM_MC_SLOW_BIT];
    end
  end

  // Control registers; enable and flag clear at reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_en_r <= 1'b0;
      warn_flag_r <= 1'b0;
      trim_r <= `SMPM_CS_TRIM_RST;
      th_field_r <= `SMPM_TH_FIELD_RST;
      th_clk_r <= `SMPM_TH_CLKSEL_RST;
      slow_sel_r <= 1'b0;
    end else begin
      irq_en_r <= irq_en_nxt;
      warn_flag_r <= warn_flag_nxt;
      trim_r <= trim_nxt;
      th_field_r <= th_field_nxt;
      th_clk_r <= th_clk_nxt;
      slow_sel_r <= slow_sel_nxt;
    end
  end

  // Pending interrupt: either flag transition counts as an event
  always_comb begin
    warn_event = (warn_flag_nxt != warn_flag_r) && irq_en_r;
    // Routine entry clears it with no write; a new event wins over that clear; disabling drops it
    pend_nxt = irq_en_r && (warn_event || (pend_r && !cpu_evt.isr_enter));
  end

  // Pending flop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // Undervoltage flag, held only by power-on reset
  always_comb begin
    uv_prev_nxt = an_s.uv_cmp;
    dip_cnt_nxt = dip_cnt_r;
    dip_halt_nxt = dip_halt_r;
    uv_flag_nxt = uv_flag_r;
    if (an_s.uv_cmp && !uv_prev_r) begin
      // Dip starts: remember whether the core was halted
      dip_cnt_nxt = 16'h0001;
      dip_halt_nxt = in_halt;
    end else if (an_s.uv_cmp && dip_cnt_r != 16'hFFFF) begin
      dip_cnt_nxt = dip_cnt_r + 16'h0001;
    end
    if (rd_cs) begin
      uv_flag_nxt = 1'b0;  // Cleared by reading control/status
    end
    // Flag set at the end of a qualifying dip; set wins over the read clear
    if (!an_s.uv_cmp && uv_prev_r && an_s.uv_det_en) begin
      if (!an_s.ext_clk_sel) begin
        // Internal clock: dips shorter than the wake time are lost
        if (dip_cnt_r >= 16'(DIP_CYCLES)) begin
          uv_flag_nxt = 1'b1;
        end
      end else if (!dip_halt_r && an_s.ext_clk_fast) begin
        uv_flag_nxt = 1'b1;  // External clock: never from Halt, needs fast clock
      end
    end
  end

  // Power-on domain flops
  always_ff @(posedge clk or negedge por_b) begin
    if (!por_b) begin
      uv_flag_r <= 1'b0;
      dip_cnt_r <= 16'h0000;
      dip_halt_r <= 1'b0;
      uv_prev_r <= 1'b0;
    end else begin
      uv_flag_r <= uv_flag_nxt;
      dip_cnt_r <= dip_cnt_nxt;
      dip_halt_r <= dip_halt_nxt;
      uv_prev_r <= uv_prev_nxt;
    end
  end

  // Power modes, interrupt mask and clock ticks
  always_comb begin
    mode_nxt = mode_r;
    mask_nxt = mask_r;
    wake_nxt = 1'b0;
    if (cpu_evt.mask_set) begin
      mask_nxt = 1'b1;
    end
    if (cpu_evt.mask_clear) begin
      mask_nxt = 1'b0;
    end
    case (mode_r)
      SMPM_RUN, SMPM_SLOW: begin
        if (cpu_evt.wait_exec) begin
          // Wait entered from Slow gives slow-wait mask cleared on entry
          mode_nxt = (mode_r == SMPM_SLOW) ? SMPM_SLOW_WAIT : SMPM_WAIT;
          mask_nxt = 1'b0;
        end else if (cpu_evt.halt_exec) begin
          mode_nxt = SMPM_HALT;
          mask_nxt = 1'b0;
        end else begin
          mode_nxt = slow_sel_r ? SMPM_SLOW : SMPM_RUN;
        end
      end
      SMPM_WAIT, SMPM_SLOW_WAIT: begin
        // Stay until an interrupt; warning interrupt wakes
        if ((pend_r && irq_en_r) || cpu_evt.other_wake) begin
          mode_nxt = slow_sel_r ? SMPM_SLOW : SMPM_RUN;
          wake_nxt = 1'b1;
        end
      end
      SMPM_HALT: begin
        // Only other sources end Halt; the warning never does
        if (cpu_evt.other_wake) begin
          mode_nxt = slow_sel_r ? SMPM_SLOW : SMPM_RUN;
          wake_nxt = 1'b1;
        end
      end
      default: begin
        mode_nxt = SMPM_RUN;
      end
    endcase
    // Request needs pending, enable and clear mask
    irq_nxt = pend_nxt && irq_en_nxt && !mask_nxt && (mode_nxt != SMPM_HALT);
    // CPU clock stops in wait peripherals keep running in wait
    case (mode_nxt)
      SMPM_RUN: begin
        cpu_tick_nxt = 1'b1;
        per_tick_nxt = 1'b1;
      end
      SMPM_SLOW: begin
        cpu_tick_nxt = slow_tick;
        per_tick_nxt = slow_tick;
      end
      SMPM_WAIT: begin
        cpu_tick_nxt = 1'b0;
        per_tick_nxt = 1'b1;
      end
      SMPM_SLOW_WAIT: begin
        cpu_tick_nxt = 1'b0;
        per_tick_nxt = slow_tick;
      end
      default: begin
        cpu_tick_nxt = 1'b0;
        per_tick_nxt = 1'b0;
      end
    endcase
  end

  // Mode flops; reset always lands in Run with mask set
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= SMPM_RUN;
      mask_r <= 1'b1;
      irq_r <= 1'b0;
      cpu_tick_r <= 1'b0;
      per_tick_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
      cpu_tick_r <= cpu_tick_nxt;
      per_tick_r <= per_tick_nxt;
      wake_r <= wake_nxt;
    end
  end

  // Outputs, all taken from flops
  assign warn_threshold_field = th_field_r;
  assign osc_trim_low_bits = trim_r;
  assign irq_req = irq_r;
  assign irq_mask = mask_r;
  assign cpu_clk_tick = cpu_tick_r;
  assign periph_clk_tick = per_tick_r;
  assign wake_pulse = wake_r;
  assign power_mode = mode_r;

endmodule

// >>> src/smpm_map.svh
// Register map, field positions, reset values and timing counts of the supply monitor.
// Assumes a 100 MHz clock and word-aligned APB access (byte address = index * 4).
`ifndef SMPM_MAP_SVH
`define SMPM_MAP_SVH

// Register indices; byte address is four times the index
`define SMPM_IDX_CTRL_STATUS 8'h3A
`define SMPM_IDX_THRESH_SEL 8'h3E
`define SMPM_IDX_MODE_CTRL 8'h40

// Control/status fields
`define SMPM_CS_IRQ_EN_BIT 0
`define SMPM_CS_WARN_BIT 1
`define SMPM_CS_UV_BIT 2
`define SMPM_CS_TRIM_LSB 5
`define SMPM_CS_TRIM_MSB 6
`define SMPM_CS_TRIM_RST 2'h3

// Threshold-select fields
`define SMPM_TH_FIELD_MSB 1
`define SMPM_TH_CLKSEL_LSB 5
`define SMPM_TH_FIELD_RST 2'h3
`define SMPM_TH_CLKSEL_RST 3'h0

// Mode-control fields
`define SMPM_MC_SLOW_BIT 0
`define SMPM_MC_MODE_LSB 2
`define SMPM_MC_MODE_MSB 4
`define SMPM_MC_MASK_BIT 7

// Timing
`define SMPM_CLK_PERIOD_NS 10
`define SMPM_DIP_TIME_NS 33000
`define SMPM_DIP_CYCLES ((`SMPM_DIP_TIME_NS + `SMPM_CLK_PERIOD_NS - 1) / `SMPM_CLK_PERIOD_NS)
`define SMPM_SLOW_DIV 32

`endif

// >>> src/smpm_pkg.sv
// Types shared by the supply monitor and power-mode logic.
// Assumes the constants of smpm_map.svh are included where numbers are needed.
package smpm_pkg;

  // Operating mode of the core
  typedef enum logic [2:0] {
    SMPM_RUN,
    SMPM_SLOW,
    SMPM_WAIT,
    SMPM_SLOW_WAIT,
    SMPM_HALT
  } smpm_mode_t;

  // Events from the CPU core, all one-cycle pulses on clk
  typedef struct packed {
    logic wait_exec;   // Wait-for-interrupt instruction executed
    logic halt_exec;   // Halt instruction executed
    logic isr_enter;   // CPU enters the supply-warning service routine
    logic mask_set;    // Global interrupt mask set (interrupt entry)
    logic mask_clear;  // Unmask instruction executed
    logic other_wake;  // Any other enabled interrupt or wake source
  } smpm_cpu_evt_t;

  // Asynchronous analog and configuration levels
  typedef struct packed {
    logic warn_cmp;      // Supply-warning comparator, 1 = below threshold
    logic uv_cmp;        // Undervoltage comparator, 1 = below threshold
    logic uv_det_en;     // Undervoltage detector enabled by option
    logic ext_clk_sel;   // External clock input selected
    logic ext_clk_fast;  // External clock above 10 MHz
  } smpm_analog_t;

endpackage

// >>> src/smpm_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent slow level.
`timescale 1ns/1ps
module smpm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;  // First stage, read only by the second
  logic [WIDTH-1:0] q_nxt;

  initial begin
    if (WIDTH < 1) $error("smpm_sync: WIDTH must be at least 1");
  end

  // Second stage simply takes the first
  always_comb begin
    q_nxt = meta_r;
  end

  // Both stages
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= q_nxt;
    end
  end

endmodule

// >>> src/smpm_tick_div.sv
// Divider that raises a one-cycle tick every RATIO clocks.
// Assumes RATIO is a power of two, as the slow-mode divider is.
`timescale 1ns/1ps
module smpm_tick_div #(
  parameter int RATIO = 32
) (
  input wire logic clk,
  input wire logic rst_b,
  output logic tick
);

  localparam int W = (RATIO > 1) ? $clog2(RATIO) : 1;
  logic [W-1:0] cnt_r;  // Free-running count
  logic [W-1:0] cnt_nxt;
  logic tick_nxt;

  initial begin
    if (RATIO < 2 || (RATIO & (RATIO - 1)) != 0) $error("smpm_tick_div: RATIO must be a power of two >= 2");
  end

  // Wrap naturally; tick when the count is at its top
  always_comb begin
    cnt_nxt = cnt_r + W'(1);
    tick_nxt = (cnt_r == W'(RATIO - 1));
  end

  // Counter and tick flop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick <= tick_nxt;
    end
  end

endmodule

// >>> testbench/smpm_properties.sv
// Checker for the supply monitor and power-mode block, bound to its top.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
module smpm_properties (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire smpm_pkg::smpm_cpu_evt_t cpu_evt,
  input wire smpm_pkg::smpm_analog_t analog_in,
  input wire logic irq_req,
  input wire logic irq_mask,
  input wire logic cpu_clk_tick,
  input wire logic periph_clk_tick,
  input wire logic wake_pulse,
  input wire smpm_pkg::smpm_mode_t power_mode
);
  import smpm_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [6:0] gap_r, gap_nxt; // Cycles since last CPU tick
  logic [6:0] run_r, run_nxt; // Cycles spent in Slow
  // Next values of the tick-spacing counters, saturating
  always_comb begin
    gap_nxt = cpu_clk_tick ? 7'h00 : gap_r + {6'h00, gap_r != 7'h7F};
    run_nxt = (power_mode != SMPM_SLOW) ? 7'h00 : run_r + {6'h00, run_r != 7'h7F};
  end
  // Counter registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_r <= 7'h00;
      run_r <= 7'h00;
    end else begin
      gap_r <= gap_nxt;
      run_r <= run_nxt;
    end
  end
  // Comparator steady and not halted for four cycles
  sequence s_calm;
    ($stable(analog_in.warn_cmp) && power_mode != SMPM_HALT) [*4];
  endsequence
  // Completed read of the control/status register
  sequence s_status_read;
    pready && !pwrite && paddr == 12'h0E8;
  endsequence
  chk_warn_live: assert property (s_calm ##0 s_status_read |-> prdata[1] == analog_in.warn_cmp)
    else $error("warning flag differs from comparator");
  chk_irq_gated: assert property (irq_req |-> !irq_mask && power_mode != SMPM_HALT)
    else $error("request while masked or halted");
  chk_isr_clear: assert property (s_calm ##0 cpu_evt.isr_enter |=> !irq_req)
    else $error("request survives service entry");
  chk_wait_entry: assert property (cpu_evt.wait_exec && power_mode inside {SMPM_RUN, SMPM_SLOW} |=>
    !irq_mask && power_mode == (($past(power_mode) == SMPM_RUN) ? SMPM_WAIT : SMPM_SLOW_WAIT))
    else $error("wrong wait entry");
  chk_wait_ticks: assert property (power_mode == SMPM_WAIT |-> !cpu_clk_tick && periph_clk_tick)
    else $error("wait clocks wrong");
  chk_halt_frozen: assert property (power_mode == SMPM_HALT && !cpu_evt.other_wake |=>
    power_mode == SMPM_HALT && !cpu_clk_tick && !periph_clk_tick)
    else $error("halt left or clocked");
  chk_wait_wake: assert property (power_mode == SMPM_WAIT && irq_req |=> wake_pulse && power_mode == SMPM_RUN)
    else $error("warning did not end wait");
  chk_slow_rate: assert property (power_mode == SMPM_SLOW && run_r > 7'h40 && cpu_clk_tick |-> gap_r == 7'h1F)
    else $error("slow tick spacing wrong");
endmodule

// >>> testbench/tb_supply_monitor_power_modes.sv
// Self-checking bench for the supply monitor and power-mode block.
// Assumes the design sources and the checker file are compiled first.
`timescale 1ns/1ps
module tb_supply_monitor_power_modes;
  import smpm_pkg::*;
  localparam logic [11:0] CS = 12'h0E8;
  localparam logic [11:0] TH = 12'h0F8;
  localparam logic [11:0] MC = 12'h100;
  localparam logic [5:0] GO_WAIT = 6'h20, HLT = 6'h10, ISR = 6'h08, MSET = 6'h04, MCLR = 6'h02, WAKE = 6'h01;
  logic clk, rst_b, por_b, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] warn_threshold_field, osc_trim_low_bits;
  logic irq_req, irq_mask, cpu_clk_tick, periph_clk_tick, wake_pulse;
  smpm_cpu_evt_t cpu_evt;
  smpm_analog_t analog_in;
  smpm_mode_t power_mode;
  int bad_count, samples_checked, nc, np;
  // Short dip filter keeps the run brief
  smpm_top #(.SLOW_DIV(32), .DIP_CYCLES(8)) DUT (.clk(clk), .rst_b(rst_b), .por_b(por_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_evt(cpu_evt), .analog_in(analog_in), .warn_threshold_field(warn_threshold_field),
    .osc_trim_low_bits(osc_trim_low_bits), .irq_req(irq_req), .irq_mask(irq_mask), .cpu_clk_tick(cpu_clk_tick),
    .periph_clk_tick(periph_clk_tick), .wake_pulse(wake_pulse), .power_mode(power_mode));
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic bad(input string m);
    bad_count++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) bad("register value");
  endtask
  task automatic chk1(input logic g, input logic e, input string m);
    samples_checked++;
    if (g !== e) bad(m);
  endtask
  task automatic chk_mode(input smpm_mode_t e);
    samples_checked++;
    if (power_mode !== e) bad("power mode");
  endtask
  // APB transfer; holds the request until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      bad("no pready");
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk32(rd, e);
  endtask
  // One-cycle CPU event, then settle
  task automatic evt(input logic [5:0] v);
    @(posedge clk);
    cpu_evt <= smpm_cpu_evt_t'(v);
    @(posedge clk);
    cpu_evt <= '0;
    @(negedge clk);
  endtask
  task automatic setw(input logic v);
    @(posedge clk);
    analog_in.warn_cmp <= v;
    repeat (6) @(negedge clk);
  endtask
  task automatic dip(input int len);
    @(posedge clk);
    analog_in.uv_cmp <= 1'b1;
    repeat (len) @(posedge clk);
    analog_in.uv_cmp <= 1'b0;
    repeat (6) @(negedge clk);
  endtask
  task automatic wait_mode(input smpm_mode_t e);
    int k;
    k = 0;
    while (power_mode !== e && k < 50) begin
      @(negedge clk);
      k++;
    end
    if (k >= 50) begin
      bad("mode not reached");
      give_verdict();
    end
    chk_mode(e);
  endtask
  // Counts CPU and peripheral ticks over a window
  task automatic count_ticks(input int len);
    nc = 0;
    np = 0;
    repeat (len) begin
      @(negedge clk);
      nc += int'(cpu_clk_tick === 1'b1);
      np += int'(periph_clk_tick === 1'b1);
    end
  endtask
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Main sequence
  initial begin
    {rst_b, por_b, psel, penable, pwrite} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    cpu_evt = '0;
    analog_in = '0;
    bad_count = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    @(negedge clk);
    chk_mode(SMPM_RUN);
    rdchk(CS, 32'h0000_0060);
    rdchk(TH, 32'h0000_0003);
    rdchk(MC, 32'h0000_0080);
    $display("test 1 reset values done");
    apb(1'b1, CS, 32'h0000_0023);
    rdchk(CS, 32'h0000_0021);
    apb(1'b1, TH, 32'h0000_00A1);
    rdchk(TH, 32'h0000_00A1);
    chk32({30'h0, warn_threshold_field}, 32'h0000_0001);
    chk32({30'h0, osc_trim_low_bits}, 32'h0000_0001);
    apb(1'b1, 12'h004, 32'h0000_00FF);
    chk1(err, 1'b1, "unmapped write");
    rdchk(12'h004, 32'h0000_0000);
    chk1(err, 1'b1, "unmapped read");
    $display("test 2 access kinds done");
    evt(MCLR);
    chk1(irq_mask, 1'b0, "mask clear");
    setw(1'b1);
    chk1(irq_req, 1'b1, "falling supply irq");
    rdchk(CS, 32'h0000_0023);
    evt(ISR);
    chk1(irq_req, 1'b0, "service entry clear");
    setw(1'b0);
    chk1(irq_req, 1'b1, "rising supply irq");
    evt(ISR);
    apb(1'b1, CS, 32'h0000_0060);
    setw(1'b1);
    chk1(irq_req, 1'b0, "disabled irq");
    setw(1'b0);
    evt(MSET);
    apb(1'b1, CS, 32'h0000_0061);
    setw(1'b1);
    chk1(irq_req, 1'b0, "masked irq");
    $display("test 3 warning interrupt done");
    evt(GO_WAIT);
    chk_mode(SMPM_WAIT);
    chk1(irq_mask, 1'b0, "wait unmask");
    chk1(cpu_clk_tick, 1'b0, "cpu stopped");
    chk1(periph_clk_tick, 1'b1, "periph runs");
    wait_mode(SMPM_RUN);
    chk1(irq_req, 1'b1, "pending wakes");
    evt(ISR);
    apb(1'b1, CS, 32'h0000_0060);
    setw(1'b0);
    evt(GO_WAIT);
    apb(1'b1, CS, 32'h0000_0061);
    chk_mode(SMPM_WAIT);
    setw(1'b1);
    wait_mode(SMPM_RUN);
    evt(ISR);
    apb(1'b1, CS, 32'h0000_0060);
    setw(1'b0);
    $display("test 4 wait mode done");
    apb(1'b1, MC, 32'h0000_0001);
    wait_mode(SMPM_SLOW);
    count_ticks(96);
    chk32(nc, 32'd3);
    rdchk(MC, 32'h0000_0005);
    evt(GO_WAIT);
    wait_mode(SMPM_SLOW_WAIT);
    count_ticks(96);
    chk32({nc[15:0], np[15:0]}, {16'd0, 16'd3});
    evt(WAKE);
    wait_mode(SMPM_SLOW);
    apb(1'b1, MC, 32'h0000_0000);
    wait_mode(SMPM_RUN);
    $display("test 5 slow mode done");
    apb(1'b1, CS, 32'h0000_0061);
    evt(HLT);
    wait_mode(SMPM_HALT);
    setw(1'b1);
    rdchk(CS, 32'h0000_0061);
    apb(1'b1, CS, 32'h0000_0060);
    chk_mode(SMPM_HALT);
    chk1(irq_req, 1'b0, "halt irq");
    setw(1'b0);
    evt(WAKE);
    wait_mode(SMPM_RUN);
    rdchk(CS, 32'h0000_0061);
    apb(1'b1, CS, 32'h0000_0060);
    $display("test 6 halt mode done");
    analog_in.uv_det_en <= 1'b1;
    dip(20);
    rdchk(CS, 32'h0000_0064);
    rdchk(CS, 32'h0000_0060);
    dip(3);
    rdchk(CS, 32'h0000_0060);
    analog_in.ext_clk_sel <= 1'b1;
    dip(20);
    rdchk(CS, 32'h0000_0060);
    analog_in.ext_clk_fast <= 1'b1;
    dip(20);
    rdchk(CS, 32'h0000_0064);
    dip(20);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rdchk(CS, 32'h0000_0064);
    $display("test 7 undervoltage flag done");
    give_verdict();
  end
endmodule
bind smpm_top smpm_properties u_chk (.clk(clk), .rst_b(rst_b), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .cpu_evt(cpu_evt), .analog_in(analog_in), .irq_req(irq_req), .irq_mask(irq_mask),
  .cpu_clk_tick(cpu_clk_tick), .periph_clk_tick(periph_clk_tick), .wake_pulse(wake_pulse), .power_mode(power_mode));
